//--- pkg/iosd_regs.svh
// Contract
// - Serial I/O cycle when type bits low and memory strobe high; drive input select.
// - Output select chosen by address follows the bit-output clock low.
// - Device codes: printer, host, link, auxiliary, clock, latch/switch 2, switches 3-4.
// - Input and output selects may coexist; input-only devices idle while read direction high.
// - Bit-output clock high during input transfers, so no output select asserts.
// - Memory strobe low asserts exactly one of eight region selects.
// - Five ROM regions, banked windows at 0xA000 and 0xC000, fixed RAM on top.
// - Inside a banked window, bank bits pick one of five RAM devices.
// - Bank code 100 is a spare bank, decoded but unused as standard.
// - Serial output cycle writes latch bit chosen by A1-A3 with value A0.
// - Power-fail reset clears every latch bit.
// - Power-fail reset deselects all banked RAM in both windows.
// - Latch bits 3-4 are spare bank bits, bits 5-7 feed host interface.
// - ROM output enable follows read direction low.
// - RAM writes on write strobe low, drives data on read direction low.
// - Data buffer enabled by memory strobe, direction from read direction.
// - Active-high copy of the write strobe / bit-output clock.
`ifndef IOSD_REGS_SVH
`define IOSD_REGS_SVH

// ----------------------------------------
// Serial I/O device map
// ----------------------------------------
`define IOSD_IO_PRINTER      16'h0000
`define IOSD_IO_HOST         16'h0040
`define IOSD_IO_LINK         16'h0080
`define IOSD_IO_AUX          16'h00C0
`define IOSD_IO_CLOCK        16'h0100
`define IOSD_LATCH_BASE      16'h0140
`define IOSD_IO_SWITCH3      16'h0180
`define IOSD_IO_SWITCH4      16'h01C0
`define IOSD_IO_SEL_LSB      6
`define IOSD_IO_SEL_MSB      8
`define IOSD_FIRST_IN_ONLY   3'h5
`define IOSD_LATCH_IDX_LSB   1
`define IOSD_LATCH_IDX_MSB   3
`define IOSD_LATCH_VAL_BIT   0
`define IOSD_LATCH_RESET     8'h00
`define IOSD_SPARE_LSB       3
`define IOSD_HOST_LSB        5

// ----------------------------------------
// Memory map
// ----------------------------------------
`define IOSD_MEM_SEL_LSB     13
`define IOSD_MEM_SEL_MSB     15
`define IOSD_BANK_COUNT      5
`define IOSD_SPARE_BANK      3'h4

// ----------------------------------------
// Pin vector layout
// ----------------------------------------
`define IOSD_PIN_W           23
`define IOSD_PIN_CYC_LSB     16
`define IOSD_PIN_CYC_MSB     18
`define IOSD_PIN_MEM         19
`define IOSD_PIN_RD          20
`define IOSD_PIN_WR          21
`define IOSD_PIN_PF          22
`define IOSD_PIN_IDLE        23'h7F_0000

`endif

//--- pkg/iosd_pkg.sv
`include "iosd_regs.svh"

package iosd_pkg;

  typedef enum logic [2:0] {
    IOSD_ROM0   = 3'h0,
    IOSD_ROM1   = 3'h1,
    IOSD_ROM2   = 3'h2,
    IOSD_ROM3   = 3'h3,
    IOSD_ROM4   = 3'h4,
    IOSD_BANK_A = 3'h5,
    IOSD_BANK_B = 3'h6,
    IOSD_FIXED  = 3'h7
  } iosd_region_t;

  typedef struct packed {
    logic [`IOSD_PIN_W-1:0] s1;
    logic [`IOSD_PIN_W-1:0] s2;
    logic [`IOSD_PIN_W-1:0] s3;
    logic [`IOSD_PIN_W-1:0] filt;
    logic                   clk_prev;
    logic [7:0]             latch;
    logic [7:0]             in_sel_n;
    logic [7:0]             out_sel_n;
    logic [7:0]             region_sel_n;
    logic [4:0]             bank_a_sel_n;
    logic [4:0]             bank_b_sel_n;
    logic                   mem_oe_n;
    logic                   mem_we_n;
    logic                   buf_en_n;
    logic                   buf_to_cpu;
    logic                   bit_clock_high;
  } iosd_state_t;

endpackage

//--- rtl/iosd_decoder.sv
`timescale 1ns/1ps

`include "iosd_regs.svh"

module iosd_decoder
  import iosd_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] addr,
  input  wire logic [2:0]  cycle_type,
  input  wire logic        memory_cycle_strobe_n,
  input  wire logic        read_direction_n,
  input  wire logic        write_or_bit_out_clock_n,
  input  wire logic        power_fail_reset_n,
  output logic      [7:0]  in_sel_n,
  output logic      [7:0]  out_sel_n,
  output logic      [7:0]  region_sel_n,
  output logic      [4:0]  bank_a_sel_n,
  output logic      [4:0]  bank_b_sel_n,
  output logic      [1:0]  spare_bank_bits,
  output logic      [2:0]  host_ctrl,
  output logic             mem_oe_n,
  output logic             mem_we_n,
  output logic             buf_en_n,
  output logic             buf_to_cpu,
  output logic             bit_clock_high
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (SYNC_STAGES != 3) begin : g_bad_sync
    $error("iosd_decoder: only three sync stages are supported");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  iosd_state_t st;
  iosd_state_t next_st;

  // Latch shares its device code with switch bank 2
  localparam logic [15:0] LATCH_BASE = `IOSD_LATCH_BASE;
  localparam logic [2:0]  LATCH_DEV  = LATCH_BASE[`IOSD_IO_SEL_MSB:`IOSD_IO_SEL_LSB];

  logic [`IOSD_PIN_W-1:0] pins;

  assign pins = {power_fail_reset_n, write_or_bit_out_clock_n, read_direction_n,
                 memory_cycle_strobe_n, cycle_type, addr};

  // Filtered view of the pins
  logic [15:0] f_addr;
  logic [2:0]  f_cyc;
  logic        f_mem_n;
  logic        f_rd_n;
  logic        f_wr_n;
  logic        f_pf_n;
  logic [2:0]  f_dev;
  logic [2:0]  f_region;
  logic [2:0]  f_bank;
  logic        f_io;

  assign f_addr   = st.filt[15:0];
  assign f_cyc    = st.filt[`IOSD_PIN_CYC_MSB:`IOSD_PIN_CYC_LSB];
  assign f_mem_n  = st.filt[`IOSD_PIN_MEM];
  assign f_rd_n   = st.filt[`IOSD_PIN_RD];
  assign f_wr_n   = st.filt[`IOSD_PIN_WR];
  assign f_pf_n   = st.filt[`IOSD_PIN_PF];
  assign f_dev    = f_addr[`IOSD_IO_SEL_MSB:`IOSD_IO_SEL_LSB];
  assign f_region = f_addr[`IOSD_MEM_SEL_MSB:`IOSD_MEM_SEL_LSB];
  assign f_bank   = st.latch[2:0];
  assign f_io     = (f_cyc == 3'h0) && f_mem_n;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [`IOSD_PIN_W-1:0] diff;
    logic [2:0]             idx;
    logic                   latch_wr;
    diff     = '0;
    idx      = '0;
    latch_wr = 1'b0;
    next_st  = st;

    // Three stages; a change counts once the last two agree
    next_st.s1   = pins;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    diff         = st.s2 ^ st.s3;
    next_st.filt = (st.filt & diff) | (st.s3 & ~diff);
    next_st.clk_prev = f_wr_n;

    // Serial I/O device selects
    next_st.in_sel_n  = 8'hFF;
    next_st.out_sel_n = 8'hFF;
    if (f_io) begin
      // Input-only devices also need read direction low
      if (f_dev < `IOSD_FIRST_IN_ONLY || !f_rd_n) begin
        next_st.in_sel_n = ~(8'h01 << f_dev);
      end
      if (!f_wr_n) begin
        next_st.out_sel_n = ~(8'h01 << f_dev);
      end
    end

    // Bank latch, written on the falling bit clock
    latch_wr = f_io && !f_wr_n && st.clk_prev && (f_dev == LATCH_DEV);
    idx      = f_addr[`IOSD_LATCH_IDX_MSB:`IOSD_LATCH_IDX_LSB];
    if (!f_pf_n) begin
      next_st.latch = `IOSD_LATCH_RESET;
    end else if (latch_wr) begin
      next_st.latch[idx] = f_addr[`IOSD_LATCH_VAL_BIT];
    end

    // Memory region decode
    next_st.region_sel_n = 8'hFF;
    if (!f_mem_n) begin
      next_st.region_sel_n = ~(8'h01 << f_region);
    end

    // Banked windows; bank 0 is selected until the bank bits are written
    next_st.bank_a_sel_n = 5'h1F;
    next_st.bank_b_sel_n = 5'h1F;
    if (f_pf_n && !f_mem_n && f_bank <= `IOSD_SPARE_BANK) begin
      if (f_region == IOSD_BANK_A) begin
        next_st.bank_a_sel_n = ~(5'h01 << f_bank);
      end
      if (f_region == IOSD_BANK_B) begin
        next_st.bank_b_sel_n = ~(5'h01 << f_bank);
      end
    end

    // Memory strobes and bus buffer
    next_st.mem_oe_n       = f_rd_n || f_mem_n;
    next_st.mem_we_n       = f_wr_n || f_mem_n;
    next_st.buf_en_n       = f_mem_n;
    next_st.buf_to_cpu     = !f_rd_n;
    next_st.bit_clock_high = !f_wr_n;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st                <= '0;
      st.s1             <= `IOSD_PIN_IDLE;
      st.s2             <= `IOSD_PIN_IDLE;
      st.s3             <= `IOSD_PIN_IDLE;
      st.filt           <= `IOSD_PIN_IDLE;
      st.clk_prev       <= 1'b1;
      st.latch          <= `IOSD_LATCH_RESET;
      st.in_sel_n       <= 8'hFF;
      st.out_sel_n      <= 8'hFF;
      st.region_sel_n   <= 8'hFF;
      st.bank_a_sel_n   <= 5'h1F;
      st.bank_b_sel_n   <= 5'h1F;
      st.mem_oe_n       <= 1'b1;
      st.mem_we_n       <= 1'b1;
      st.buf_en_n       <= 1'b1;
      st.buf_to_cpu     <= 1'b0;
      st.bit_clock_high <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign in_sel_n        = st.in_sel_n;
  assign out_sel_n       = st.out_sel_n;
  assign region_sel_n    = st.region_sel_n;
  assign bank_a_sel_n    = st.bank_a_sel_n;
  assign bank_b_sel_n    = st.bank_b_sel_n;
  assign spare_bank_bits = st.latch[`IOSD_SPARE_LSB+1:`IOSD_SPARE_LSB];
  assign host_ctrl       = st.latch[`IOSD_HOST_LSB+2:`IOSD_HOST_LSB];
  assign mem_oe_n        = st.mem_oe_n;
  assign mem_we_n        = st.mem_we_n;
  assign buf_en_n        = st.buf_en_n;
  assign buf_to_cpu      = st.buf_to_cpu;
  assign bit_clock_high  = st.bit_clock_high;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_io_in_sel;
    f_io && f_dev < `IOSD_FIRST_IN_ONLY |=> in_sel_n == ~(8'h01 << $past(f_dev));
  endproperty
  a_io_in_sel: assert property (p_io_in_sel) else $error("input select missing");

  property p_no_io;
    !f_io |=> in_sel_n == 8'hFF && out_sel_n == 8'hFF;
  endproperty
  a_no_io: assert property (p_no_io) else $error("select outside io cycle");

  property p_out_follow;
    f_io && !f_wr_n |=> out_sel_n == ~(8'h01 << $past(f_dev));
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output select not following clock");

  property p_out_idle;
    f_wr_n |=> out_sel_n == 8'hFF;
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("output select during input");

  property p_in_only;
    f_io && f_rd_n && f_dev >= `IOSD_FIRST_IN_ONLY |=> in_sel_n == 8'hFF;
  endproperty
  a_in_only: assert property (p_in_only) else $error("input-only device active");

  property p_region;
    !f_mem_n |=> $onehot(~region_sel_n) && !region_sel_n[$past(f_region)];
  endproperty
  a_region: assert property (p_region) else $error("region decode wrong");

  property p_bank_a;
    !f_mem_n && f_pf_n && f_region == IOSD_BANK_A && f_bank < 3'h5
      |=> bank_a_sel_n == ~(5'h01 << $past(f_bank)) && bank_b_sel_n == 5'h1F;
  endproperty
  a_bank_a: assert property (p_bank_a) else $error("bank window A decode wrong");

  property p_bank_high;
    f_bank > `IOSD_SPARE_BANK |=> bank_a_sel_n == 5'h1F && bank_b_sel_n == 5'h1F;
  endproperty
  a_bank_high: assert property (p_bank_high) else $error("high bank code selected ram");

  property p_pf;
    !f_pf_n |=> st.latch == 8'h00 && bank_a_sel_n == 5'h1F && bank_b_sel_n == 5'h1F;
  endproperty
  a_pf: assert property (p_pf) else $error("power-fail did not clear");

  property p_latch_wr;
    f_pf_n && f_io && !f_wr_n && st.clk_prev && f_dev == 3'h5
      |=> st.latch[$past(f_addr[3:1])] == $past(f_addr[0]);
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch bit not written");

  property p_buf;
    1'b1 |=> buf_en_n == $past(f_mem_n) && buf_to_cpu == !$past(f_rd_n)
             && bit_clock_high == !$past(f_wr_n);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer control wrong");

  property p_mem_strobes;
    !f_mem_n && !f_rd_n |=> !mem_oe_n ##1 1'b1;
  endproperty
  a_mem_strobes: assert property (p_mem_strobes) else $error("memory read enable missing");

  property p_io_in_rd;
    f_io && !f_rd_n |=> in_sel_n == ~(8'h01 << $past(f_dev));
  endproperty
  a_io_in_rd: assert property (p_io_in_rd) else $error("input select missing on read");

  property p_bank_b;
    !f_mem_n && f_pf_n && f_region == IOSD_BANK_B && f_bank < 3'h5
      |=> bank_b_sel_n == ~(5'h01 << $past(f_bank)) && bank_a_sel_n == 5'h1F;
  endproperty
  a_bank_b: assert property (p_bank_b) else $error("bank window B decode wrong");

  property p_spare_bank;
    !f_mem_n && f_pf_n && f_region == IOSD_BANK_A && f_bank == `IOSD_SPARE_BANK
      |=> bank_a_sel_n == 5'h0F;
  endproperty
  a_spare_bank: assert property (p_spare_bank) else $error("spare bank not selected");

  property p_bank_a_idle;
    f_mem_n || f_region != IOSD_BANK_A |=> bank_a_sel_n == 5'h1F;
  endproperty
  a_bank_a_idle: assert property (p_bank_a_idle) else $error("window A select outside window");

  property p_bank_b_idle;
    f_mem_n || f_region != IOSD_BANK_B |=> bank_b_sel_n == 5'h1F;
  endproperty
  a_bank_b_idle: assert property (p_bank_b_idle) else $error("window B select outside window");

  property p_region_idle;
    f_mem_n |=> region_sel_n == 8'hFF;
  endproperty
  a_region_idle: assert property (p_region_idle) else $error("region select without strobe");

  property p_mem_we;
    !f_mem_n && !f_wr_n |=> !mem_we_n;
  endproperty
  a_mem_we: assert property (p_mem_we) else $error("memory write strobe missing");

  property p_mem_idle;
    f_mem_n |=> mem_we_n && mem_oe_n && buf_en_n;
  endproperty
  a_mem_idle: assert property (p_mem_idle) else $error("memory strobes outside memory cycle");

  property p_latch_hold;
    f_pf_n && !(f_io && !f_wr_n && st.clk_prev && f_dev == LATCH_DEV)
      |=> $stable(st.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

  property p_spare_wr;
    f_pf_n && f_io && !f_wr_n && st.clk_prev && f_dev == LATCH_DEV && f_addr[3:1] == 3'h3
      |=> spare_bank_bits[0] == $past(f_addr[0]);
  endproperty
  a_spare_wr: assert property (p_spare_wr) else $error("spare bank bit not written");

endmodule

//--- testbench/iosd_cpu_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Processor bus model
// ----------------------------------------
module iosd_cpu_model (
  input  wire logic        clk_sys,
  output logic      [15:0] addr,
  output logic      [2:0]  cycle_type,
  output logic             mem_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             pf_n
);
  initial begin
    addr = 16'h0000;
    cycle_type = 3'h7;
    mem_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    pf_n = 1'b1;
  end

  // Pins held long enough to pass the sync and glitch filter
  task automatic set_pins(input logic [15:0] a, input logic [2:0] ct, input logic m, input logic rd,
                          input logic wr);
    @(posedge clk_sys);
    addr <= a;
    cycle_type <= ct;
    mem_n <= m;
    rd_n <= rd;
    wr_n <= wr;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  // Address settles before the bit clock falls
  task automatic io_write(input logic [2:0] idx, input logic val);
    set_pins(16'h0140 | {12'h000, idx, val}, 3'h0, 1'b1, 1'b1, 1'b1);
    set_pins(16'h0140 | {12'h000, idx, val}, 3'h0, 1'b1, 1'b1, 1'b0);
    set_pins(16'h0140 | {12'h000, idx, val}, 3'h0, 1'b1, 1'b1, 1'b1);
    set_pins(16'h0000, 3'h7, 1'b1, 1'b1, 1'b1);
  endtask

  task automatic set_pf(input logic v);
    @(posedge clk_sys);
    pf_n <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
endmodule

//--- testbench/tb_io_select_and_memory_bank_decoder.sv
`timescale 1ns/1ps

module tb_io_select_and_memory_bank_decoder;
  logic        clk_sys;
  logic        rstn;
  logic [15:0] addr;
  logic [2:0]  cycle_type;
  logic        mem_n, rd_n, wr_n, pf_n;
  logic [7:0]  in_sel_n, out_sel_n, region_sel_n;
  logic [4:0]  bank_a_sel_n, bank_b_sel_n;
  logic [1:0]  spare_bank_bits;
  logic [2:0]  host_ctrl;
  logic        mem_oe_n, mem_we_n, buf_en_n, buf_to_cpu, bit_clock_high;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  iosd_cpu_model cpu (.clk_sys(clk_sys), .addr(addr), .cycle_type(cycle_type), .mem_n(mem_n),
                      .rd_n(rd_n), .wr_n(wr_n), .pf_n(pf_n));

  iosd_decoder #(.SYNC_STAGES(3)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .cycle_type(cycle_type),
    .memory_cycle_strobe_n(mem_n), .read_direction_n(rd_n), .write_or_bit_out_clock_n(wr_n),
    .power_fail_reset_n(pf_n), .in_sel_n(in_sel_n), .out_sel_n(out_sel_n),
    .region_sel_n(region_sel_n), .bank_a_sel_n(bank_a_sel_n), .bank_b_sel_n(bank_b_sel_n),
    .spare_bank_bits(spare_bank_bits), .host_ctrl(host_ctrl), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .buf_en_n(buf_en_n), .buf_to_cpu(buf_to_cpu),
    .bit_clock_high(bit_clock_high));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  function automatic logic [7:0] sel_n(input int k);
    return ~(8'h01 << k);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is about 1200 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("region_sel_n", region_sel_n, 8'hff);
    check("latch", {host_ctrl, spare_bank_bits}, 5'h00);
    for (int c = 0; c < 8; c++) begin
      cpu.set_pins({7'h00, c[2:0], 6'h00}, 3'h0, 1'b1, 1'b0, 1'b1);
      check("in_sel_n", in_sel_n, sel_n(c));
      check("out_sel_n", out_sel_n, 8'hff);
    end
    cpu.set_pins(16'h0040, 3'h4, 1'b1, 1'b0, 1'b1);
    check("in_sel_n", in_sel_n, 8'hff);
    cpu.set_pins(16'h0040, 3'h0, 1'b0, 1'b0, 1'b1);
    check("in_sel_n", in_sel_n, 8'hff);
    check("region_sel_n", region_sel_n, sel_n(0));
    // Shared address: output latch and input switches
    cpu.set_pins(16'h0140, 3'h0, 1'b1, 1'b1, 1'b1);
    cpu.set_pins(16'h0140, 3'h0, 1'b1, 1'b1, 1'b0);
    check("out_sel_n", out_sel_n, sel_n(5));
    check("in_sel_n", in_sel_n, 8'hff);
    check("bit_clock_high", bit_clock_high, 1'b1);
    cpu.set_pins(16'h0040, 3'h0, 1'b1, 1'b1, 1'b0);
    check("in_sel_n", in_sel_n, sel_n(1));
    check("out_sel_n", out_sel_n, sel_n(1));
    cpu.set_pins(16'h0040, 3'h0, 1'b1, 1'b1, 1'b1);
    check("out_sel_n", out_sel_n, 8'hff);
    check("in_sel_n", in_sel_n, sel_n(1));
    cpu.set_pins(16'h0000, 3'h7, 1'b1, 1'b1, 1'b1);
    check("out_sel_n", out_sel_n, 8'hff);
    cpu.io_write(3'h3, 1'b1);
    cpu.io_write(3'h6, 1'b1);
    check("latch", {host_ctrl, spare_bank_bits}, 5'h09);
    cpu.io_write(3'h3, 1'b0);
    cpu.io_write(3'h6, 1'b0);
    for (int b = 0; b < 8; b++) begin
      cpu.io_write(3'h0, b[0]);
      cpu.io_write(3'h1, b[1]);
      cpu.io_write(3'h2, b[2]);
      cpu.set_pins(16'hA000, 3'h7, 1'b0, 1'b0, 1'b1);
      check("bank_a_sel_n", {3'h7, bank_a_sel_n}, b < 5 ? sel_n(b) : 8'hff);
      check("bank_b_sel_n", bank_b_sel_n, 5'h1f);
      cpu.set_pins(16'hC000, 3'h7, 1'b0, 1'b0, 1'b1);
      check("bank_b_sel_n", {3'h7, bank_b_sel_n}, b < 5 ? sel_n(b) : 8'hff);
      check("bank_a_sel_n", bank_a_sel_n, 5'h1f);
    end
    for (int r = 0; r < 8; r++) begin
      cpu.set_pins({r[2:0], 13'h0000}, 3'h7, 1'b0, 1'b0, 1'b1);
      check("region_sel_n", region_sel_n, sel_n(r));
      check("mem_oe_n", mem_oe_n, 1'b0);
      check("buf", {buf_en_n, buf_to_cpu}, 2'b01);
    end
    cpu.set_pins(16'hE000, 3'h7, 1'b0, 1'b1, 1'b0);
    check("mem_we_n", mem_we_n, 1'b0);
    check("mem_oe_n", mem_oe_n, 1'b1);
    check("buf_to_cpu", buf_to_cpu, 1'b0);
    cpu.set_pins(16'h0000, 3'h7, 1'b1, 1'b1, 1'b1);
    check("buf_en_n", buf_en_n, 1'b1);
    cpu.io_write(3'h0, 1'b0);
    cpu.io_write(3'h2, 1'b0);
    cpu.set_pins(16'hA000, 3'h7, 1'b0, 1'b0, 1'b1);
    check("bank_a_sel_n", bank_a_sel_n, 5'h1b);
    cpu.set_pf(1'b0);
    check("bank_a_sel_n", bank_a_sel_n, 5'h1f);
    cpu.set_pf(1'b1);
    check("bank_a_sel_n", bank_a_sel_n, 5'h1e);
    summarize();
  end
endmodule
